// file: core/fetch_execute_sequencer.sv
/*
 * Two-stage fetch/execute sequencer: program counter, instruction latch,
 * execute stage, branch flush and vectoring. Program memory is on-chip,
 * combinational on o_prog_addr and on the same clock. The execute unit
 * outside decodes o_exec_instr and reports its own counter loads.
 */
`timescale 1ns/100ps
module fetch_execute_sequencer
    import fetch_sequencer_pkg::*;
#(
    parameter logic [1:0] MEM_SIZE = SIZE_2K
)(
    input  wire logic                   i_mclk,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_master_clear_n,
    input  wire logic                   i_rc_mode,
    input  wire logic [INSTR_WIDTH-1:0] i_prog_data,
    input  wire logic                   i_irq_accept,
    input  wire logic                   i_pc_load,
    input  wire logic [PC_WIDTH-1:0]    i_pc_target,
    output logic      [PC_WIDTH-1:0]    o_prog_addr,
    output logic      [INSTR_WIDTH-1:0] o_exec_instr,
    output logic                        o_exec_valid,
    output logic                        o_data_rd_strobe,
    output logic                        o_data_wr_strobe,
    output logic                        o_phase_one,
    output logic                        o_phase_two,
    output logic                        o_phase_three,
    output logic                        o_phase_four,
    output logic                        o_cycle_rate
);

    localparam logic [PC_WIDTH-1:0] ADDR_MASK =
        (MEM_SIZE == SIZE_512) ? MASK_512 :
        (MEM_SIZE == SIZE_1K)  ? MASK_1K  : MASK_2K;

    // Master clear synchroniser
    logic master_clear_n_meta;
    logic master_clear_n_sync;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            master_clear_n_meta <= 1'b0;
            master_clear_n_sync <= 1'b0;
        end else begin
            master_clear_n_meta <= i_master_clear_n;
            master_clear_n_sync <= master_clear_n_meta;
        end
    end

    logic run;
    assign run = master_clear_n_sync;

    logic phase_one;
    logic phase_two;
    logic phase_three;
    logic phase_four;

    phase_generator u_phase (
        .i_mclk        (i_mclk),
        .i_sys_rst     (i_sys_rst),
        .i_run         (run),
        .o_phase_one   (phase_one),
        .o_phase_two   (phase_two),
        .o_phase_three (phase_three),
        .o_phase_four  (phase_four)
    );

    // Pipeline state
    logic [PC_WIDTH-1:0]    pc;
    logic                   started;
    logic [INSTR_WIDTH-1:0] instr_latch;
    logic                   latch_valid;
    logic [INSTR_WIDTH-1:0] exec_instr;
    logic                   exec_valid;
    logic                   pend_irq;
    logic                   pend_load;
    logic [PC_WIDTH-1:0]    pend_target;
    logic                   cycle_rate;

    logic [PC_WIDTH-1:0]    next_pc;
    logic                   next_started;
    logic [INSTR_WIDTH-1:0] next_instr_latch;
    logic                   next_latch_valid;
    logic [INSTR_WIDTH-1:0] next_exec_instr;
    logic                   next_exec_valid;
    logic                   next_pend_irq;
    logic                   next_pend_load;
    logic [PC_WIDTH-1:0]    next_pend_target;
    logic                   next_cycle_rate;

    logic                   jump_now;
    logic                   take;
    logic [PC_WIDTH-1:0]    target;

    // Jump decoded from the instruction that is finishing execution
    assign jump_now = exec_valid &&
        (exec_instr[JUMP_OP_MSB:JUMP_OP_LSB] == JUMP_OPCODE);
    assign take = pend_irq || jump_now || pend_load;

    always_comb begin
        // Interrupt wins over a jump or load in the same cycle
        if (pend_irq) begin
            target = IRQ_VECTOR;
        end else if (jump_now) begin
            target = {{(PC_WIDTH-JUMP_LIT_W){1'b0}}, exec_instr[JUMP_LIT_W-1:0]};
        end else begin
            target = pend_target;
        end
    end

    always_comb begin
        next_pc          = pc;
        next_started     = started;
        next_instr_latch = instr_latch;
        next_latch_valid = latch_valid;
        next_exec_instr  = exec_instr;
        next_exec_valid  = exec_valid;
        next_pend_irq    = pend_irq || i_irq_accept;
        next_pend_load   = pend_load;
        next_pend_target = pend_target;
        next_cycle_rate  = cycle_rate;

        if (!run) begin
            next_pc          = RESET_VECTOR;
            next_started     = 1'b0;
            next_latch_valid = 1'b0;
            next_exec_valid  = 1'b0;
            next_pend_irq    = 1'b0;
            next_pend_load   = 1'b0;
            next_pend_target = RESET_VECTOR;
            next_cycle_rate  = 1'b0;
        end else begin
            if (phase_one) begin
                // Counter steps and the next fetch begins
                if (!started) begin
                    next_pc = RESET_VECTOR;
                end else if (take) begin
                    next_pc = target & ADDR_MASK;
                end else begin
                    next_pc = (pc + PC_STEP) & ADDR_MASK;
                end
                next_started = 1'b1;
                // Latched word enters execute; dropped on a redirect
                next_exec_instr = instr_latch;
                next_exec_valid = latch_valid && !take;
                // An interrupt request landing in this same cycle is kept
                next_pend_irq  = i_irq_accept;
                next_pend_load = 1'b0;
            end
            if (phase_four) begin
                next_instr_latch = i_prog_data;
                next_latch_valid = started;
                if (i_pc_load && exec_valid) begin
                    next_pend_load   = 1'b1;
                    next_pend_target = i_pc_target;
                end
            end
            // Low in the first half cycle, high in the second
            if (phase_two) begin
                next_cycle_rate = i_rc_mode;
            end else if (phase_four) begin
                next_cycle_rate = 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pc          <= RESET_VECTOR;
            started     <= 1'b0;
            instr_latch <= '0;
            latch_valid <= 1'b0;
            exec_instr  <= '0;
            exec_valid  <= 1'b0;
            pend_irq    <= 1'b0;
            pend_load   <= 1'b0;
            pend_target <= RESET_VECTOR;
            cycle_rate  <= 1'b0;
        end else begin
            pc          <= next_pc;
            started     <= next_started;
            instr_latch <= next_instr_latch;
            latch_valid <= next_latch_valid;
            exec_instr  <= next_exec_instr;
            exec_valid  <= next_exec_valid;
            pend_irq    <= next_pend_irq;
            pend_load   <= next_pend_load;
            pend_target <= next_pend_target;
            cycle_rate  <= next_cycle_rate;
        end
    end

    assign o_prog_addr      = pc;
    assign o_exec_instr     = exec_instr;
    assign o_exec_valid     = exec_valid;
    // Flushed slots never strobe data memory
    assign o_data_rd_strobe = phase_two && exec_valid;
    assign o_data_wr_strobe = phase_four && exec_valid;
    assign o_phase_one      = phase_one;
    assign o_phase_two      = phase_two;
    assign o_phase_three    = phase_three;
    assign o_phase_four     = phase_four;
    assign o_cycle_rate     = cycle_rate;

endmodule

// file: core/fetch_sequencer_pkg.sv
/*
 * Constants shared by the fetch/execute sequencer and its phase generator.
 * Assumes a single clock: the oscillator input feeds i_mclk directly.
 */
package fetch_sequencer_pkg;

    localparam int PC_WIDTH    = 13;
    localparam int INSTR_WIDTH = 14;

    localparam logic [PC_WIDTH-1:0] RESET_VECTOR = 13'h0000;
    localparam logic [PC_WIDTH-1:0] IRQ_VECTOR   = 13'h0004;
    localparam logic [PC_WIDTH-1:0] PC_STEP      = 13'h0001;

    // Address masks for the three memory sizes
    localparam logic [PC_WIDTH-1:0] MASK_512 = 13'h01ff;
    localparam logic [PC_WIDTH-1:0] MASK_1K  = 13'h03ff;
    localparam logic [PC_WIDTH-1:0] MASK_2K  = 13'h07ff;

    localparam logic [1:0] SIZE_512 = 2'h0;
    localparam logic [1:0] SIZE_1K  = 2'h1;
    localparam logic [1:0] SIZE_2K  = 2'h2;

    // Jump opcode: top three bits, literal in the low eleven
    localparam int             JUMP_OP_MSB = 13;
    localparam int             JUMP_OP_LSB = 11;
    localparam logic [2:0]     JUMP_OPCODE = 3'h5;
    localparam int             JUMP_LIT_W  = 11;

    // Gray-coded phase sequence
    typedef enum logic [1:0] {
        PH_ONE   = 2'h0,
        PH_TWO   = 2'h1,
        PH_THREE = 2'h3,
        PH_FOUR  = 2'h2
    } phase_type;

endpackage

// file: core/phase_generator.sv
/*
 * Four-phase divider: one-cycle enable pulses for each quarter of an
 * instruction cycle. Assumes i_run is already synchronous to i_mclk.
 */
`timescale 1ns/100ps
module phase_generator
    import fetch_sequencer_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_sys_rst,
    input  wire logic i_run,
    output logic      o_phase_one,
    output logic      o_phase_two,
    output logic      o_phase_three,
    output logic      o_phase_four
);

    phase_type phase;
    phase_type next_phase;

    always_comb begin
        if (!i_run) begin
            next_phase = PH_ONE;
        end else begin
            case (phase)
                PH_ONE:   next_phase = PH_TWO;
                PH_TWO:   next_phase = PH_THREE;
                PH_THREE: next_phase = PH_FOUR;
                PH_FOUR:  next_phase = PH_ONE;
                default:  next_phase = PH_ONE;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase <= PH_ONE;
        end else begin
            phase <= next_phase;
        end
    end

    // Held idle while stopped so no phase fires under master clear
    assign o_phase_one   = i_run && (phase == PH_ONE);
    assign o_phase_two   = i_run && (phase == PH_TWO);
    assign o_phase_three = i_run && (phase == PH_THREE);
    assign o_phase_four  = i_run && (phase == PH_FOUR);

endmodule

// file: sim/prog_mem_model.sv
/*
 * Program memory model: combinational 14-bit words.
 * Assumes the sequencer reads it on i_mclk with no wait states.
 */
`timescale 1ns/100ps
module prog_mem_model
    import fetch_sequencer_pkg::*;
(
    input  wire logic [12:0] i_addr,
    output logic      [13:0] o_data
);
    // One word per address, a jump to 020h sits at 010h
    always_comb begin
        o_data = {3'h0, i_addr[10:0]};
        if (i_addr == 13'h0010) begin
            o_data = {JUMP_OPCODE, 11'h020};
        end
    end
endmodule

// file: sim/fetch_execute_sequencer_asserts.sv
/*
 * Checker for the sequencer ports.
 * Assumes master clear is held low over every reset.
 */
`timescale 1ns/100ps
module fetch_execute_sequencer_asserts
    import fetch_sequencer_pkg::*;
#(
    parameter logic [1:0] MEM_SIZE = SIZE_2K
)(
    input wire logic        i_mclk,
    input wire logic        i_sys_rst,
    input wire logic        i_master_clear_n,
    input wire logic        i_rc_mode,
    input wire logic [13:0] i_prog_data,
    input wire logic        i_irq_accept,
    input wire logic        i_pc_load,
    input wire logic [12:0] i_pc_target,
    input wire logic [12:0] o_prog_addr,
    input wire logic [13:0] o_exec_instr,
    input wire logic        o_exec_valid,
    input wire logic        o_data_rd_strobe,
    input wire logic        o_data_wr_strobe,
    input wire logic        o_phase_one,
    input wire logic        o_phase_two,
    input wire logic        o_phase_three,
    input wire logic        o_phase_four,
    input wire logic        o_cycle_rate
);
    localparam logic [12:0] MASK = (MEM_SIZE == SIZE_512) ? MASK_512 :
                                   (MEM_SIZE == SIZE_1K) ? MASK_1K : MASK_2K;
    logic [12:0] tgt;
    logic        jmp;
    assign jmp = o_exec_valid && (o_exec_instr[13:11] == JUMP_OPCODE);
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tgt <= 13'h0000;
        end else if (o_phase_two && jmp) begin
            tgt <= {2'h0, o_exec_instr[10:0]} & MASK;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst || !i_master_clear_n);
    sequence s_rest;
        o_phase_two ##1 o_phase_three ##1 o_phase_four ##1 o_phase_one;
    endsequence
    sequence s_flush;
        (!o_exec_valid && !o_data_rd_strobe) ##2 (!o_exec_valid && !o_data_wr_strobe);
    endsequence
    a_phase_onehot: assert property ($onehot0({o_phase_one, o_phase_two, o_phase_three,
        o_phase_four})) else $error("phases overlap");
    a_phase_order: assert property (o_phase_one |=> s_rest)
        else $error("phase order");
    a_addr_hold: assert property (!o_phase_one |=> $stable(o_prog_addr))
        else $error("address moved outside phase one");
    a_addr_range: assert property ((o_prog_addr & ~MASK) == 13'h0000)
        else $error("address beyond memory");
    // Word enters execute at the edge closing the following phase one
    a_latch_word: assert property (o_phase_four ##2 o_exec_valid |->
        o_exec_instr == $past(i_prog_data, 2)) else $error("latched word wrong");
    a_rd_strobe: assert property (o_data_rd_strobe == (o_phase_two && o_exec_valid))
        else $error("read strobe wrong");
    a_wr_strobe: assert property (o_data_wr_strobe == (o_phase_four && o_exec_valid))
        else $error("write strobe wrong");
    a_jump_flush: assert property (o_phase_two && jmp |-> ##4 s_flush)
        else $error("slot after jump not flushed");
    a_jump_target: assert property (o_phase_two && jmp |=> ##[0:6]
        (o_prog_addr == tgt || o_prog_addr == IRQ_VECTOR)) else $error("jump target missed");
    a_irq_vector: assert property (i_irq_accept && o_phase_two |-> ##[1:6]
        o_prog_addr == IRQ_VECTOR) else $error("interrupt vector missed");
    // Mode is sampled at phase two, so it must have stood for two edges
    a_rc_rate: assert property (i_rc_mode && $past(i_rc_mode) && $past(i_rc_mode, 2) |->
        o_cycle_rate == (o_phase_three || o_phase_four)) else $error("cycle rate wrong");
endmodule
bind fetch_execute_sequencer fetch_execute_sequencer_asserts #(.MEM_SIZE(MEM_SIZE)) u_chk (.*);

// file: sim/tb_top.sv
/*
 * Self-checking bench for the sequencer.
 * Assumes the combinational program memory model beside it.
 */
`timescale 1ns/100ps
module tb_top;
    import fetch_sequencer_pkg::*;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_master_clear_n = 1'b0;
    logic i_rc_mode = 1'b0;
    logic i_irq_accept = 1'b0;
    logic i_pc_load = 1'b0;
    logic [12:0] i_pc_target = 13'h0000;
    logic [13:0] i_prog_data;
    logic [12:0] o_prog_addr;
    logic [13:0] o_exec_instr;
    logic o_exec_valid, o_data_rd_strobe, o_data_wr_strobe, o_cycle_rate;
    logic o_phase_one, o_phase_two, o_phase_three, o_phase_four;
    logic [14:0] slots [$];
    int n_fail = 0;
    int checked = 0;
    fetch_execute_sequencer u_dut (.*);
    prog_mem_model u_mem (.i_addr(o_prog_addr), .o_data(i_prog_data));
    always #5 i_mclk = ~i_mclk;
    // Execute slot as seen in its phase two
    // Mid-cycle, away from the edge that moves the phase register
    always @(negedge i_mclk) if (o_phase_two) slots.push_back({o_exec_valid, o_exec_instr});
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic wait_addr(input logic [12:0] a);
        for (int k = 0; k < 400 && o_prog_addr !== a; k++) cyc(1);
        check("prog_addr", {3'h0, a}, {3'h0, o_prog_addr});
    endtask
    task automatic t_start();
        for (int k = 0; k < 20 && o_phase_one !== 1'b1; k++) cyc(1);
        check("first phase_one", 16'h1, {15'h0, o_phase_one});
        check("start addr", 16'h0, {3'h0, o_prog_addr});
        cyc(1);
        check("first cycle addr", 16'h0, {3'h0, o_prog_addr});
        cyc(4);
        check("addr after phase_one", 16'h1, {3'h0, o_prog_addr});
    endtask
    task automatic t_jump();
        int i;
        slots.delete();
        wait_addr(13'h0020);
        cyc(12);
        for (i = 1; i + 2 < slots.size() && slots[i] !== {4'hd, 11'h020}; i++);
        check("before jump", 16'h400f, {1'b0, slots[i-1]});
        check("flushed slot", 16'h0, {15'h0, slots[i+1][14]});
        check("jump landing", 16'h4020, {1'b0, slots[i+2]});
    endtask
    task automatic t_wrap();
        for (int k = 0; k < 20 && !(o_phase_four && o_exec_valid); k++) cyc(1);
        i_pc_load = 1'b1;
        i_pc_target = 13'h1fff;
        cyc(1);
        i_pc_load = 1'b0;
        wait_addr(13'h07ff);
        wait_addr(13'h0000);
    endtask
    task automatic t_irq();
        for (int k = 0; k < 8 && o_phase_two !== 1'b1; k++) cyc(1);
        i_irq_accept = 1'b1;
        cyc(1);
        i_irq_accept = 1'b0;
        wait_addr(IRQ_VECTOR);
    endtask
    task automatic t_rc();
        int n;
        n = 0;
        i_rc_mode = 1'b1;
        cyc(2);
        for (int k = 0; k < 8; k++) begin
            n += o_cycle_rate;
            cyc(1);
        end
        i_rc_mode = 1'b0;
        check("cycle_rate highs", 16'h4, n[15:0]);
    endtask
    task automatic t_master_clear_n();
        i_master_clear_n = 1'b0;
        cyc(6);
        check("cleared addr", 16'h0, {3'h0, o_prog_addr});
        i_master_clear_n = 1'b1;
        t_start();
    endtask
    task automatic results();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        cyc(2);
        i_sys_rst = 1'b0;
        cyc(1);
        i_master_clear_n = 1'b1;
        t_start();
        t_jump();
        t_wrap();
        t_irq();
        t_rc();
        t_master_clear_n();
        results();
    end
    // Whole run needs about 130 cycles
    initial begin
        #200000;
        n_fail++;
        results();
    end
endmodule
